/* logic/bond_pkg.sv */
package bond_pkg;
	// channel count and apb geometry
	localparam int          NUM_CH     = 4;
	localparam int          ADDR_W     = 8;
	localparam logic [7:0]  ADDR_CTRL  = 8'h00;
	localparam logic [7:0]  ADDR_STAT  = 8'h04;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [3:0]  GROUP_ALL  = 4'hF;

	// bond status line codes, as the master drives them
	localparam logic [1:0]  BS_RESERVED = 2'h0;
	localparam logic [1:0]  BS_INSERT   = 2'h1;
	localparam logic [1:0]  BS_DELETE   = 2'h2;
	localparam logic [1:0]  BS_NORMAL   = 2'h3;

	// pin synchroniser reset value: pull levels of the pads
	// {master_sel, bond_inhibit_n, sel_hi, sel_lo, lines[1:0], all_bonded}
	localparam logic [6:0]  PIN_RESET   = 7'h27;
	localparam int          PIN_W       = 7;

	// control register layout
	typedef struct packed {
		logic [22:0] reserved_hi;
		logic        restart;
		logic [2:0]  reserved_lo;
		logic        ref_clocked;
		logic [3:0]  group;
	} ctrl_type;

	// status register layout
	typedef struct packed {
		logic [15:0] reserved_hi;
		logic [3:0]  adjust_en;
		logic [3:0]  seq_detected;
		logic [1:0]  reserved_lo;
		logic [1:0]  lines;
		logic        all_bonded;
		logic        resolved;
		logic        active;
		logic        master;
	} stat_type;

	// per-channel receive indications from the channel pipelines
	typedef struct packed {
		logic [3:0] framing_valid;
		logic [3:0] seq_detected;
		logic [3:0] framing_char;
		logic [3:0] eb_add;
		logic [3:0] eb_drop;
	} rx_chan_type;

	// bonding resolution states
	typedef enum logic [2:0] {
		RES_OFF     = 3'b001,
		RES_RESOLVE = 3'b010,
		RES_DONE    = 3'b100
	} res_state_type;
endpackage : bond_pkg

/* logic/pin_sync2.sv */
`timescale 1ns/10ps
`default_nettype none
module pin_sync2 #(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rstn,
	// level in and out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	// two flops; only the second stage is read downstream
	always_ff @(posedge clk) begin
		if (!rstn) begin
			meta <= RST_VAL;
			q    <= RST_VAL;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : pin_sync2
`default_nettype wire

/* logic/multi_device_channel_bonding_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - strap low in bonding mode: act as master, drive the bond status lines.
// - strap high in bonding mode: act as slave, bond status lines are inputs.
// - strap ignored unless four-channel group and reference-clocked interface.
// - all-bonded is active high open drain, wired-AND across the domain.
// - pull all-bonded low while resolving; release only when all framing valid.
// - drive all-bonded only in four-channel reference-clocked mode.
// - inhibit low: no offset adjust until all bonded channels saw the sequence.
// - inhibit high: each channel that saw the sequence aligns on its own.
// - a group bonds only if the selected master channel is a member.
// - line codes: 01 insert comma, 10 delete framing char, 11 normal.
// - master updates lines at character rate from its master channel buffer.
module multi_device_channel_bonding_ctrl (
	// clock and reset
	input  wire logic                       SYS_CLK,
	input  wire logic                       RSTN,
	// apb slave
	input  wire logic                       PSEL,
	input  wire logic                       PENABLE,
	input  wire logic                       PWRITE,
	input  wire logic [bond_pkg::ADDR_W-1:0] PADDR,
	input  wire logic [31:0]                PWDATA,
	output logic      [31:0]                PRDATA,
	output logic                            PREADY,
	output logic                            PSLVERR,
	// strap and select pins
	input  wire logic                       MASTER_SEL,
	input  wire logic                       BOND_INHIBIT_N,
	input  wire logic                       MASTER_CHANNEL_SELECT_LO,
	input  wire logic                       MASTER_CHANNEL_SELECT_HI,
	// bond status lines, open drain
	input  wire logic [1:0]                 BOND_STATUS_LINES_IN,
	output logic      [1:0]                 BOND_STATUS_LINES_OUT,
	output logic      [1:0]                 BOND_STATUS_LINES_OE_N,
	// all-bonded indicator, open drain
	input  wire logic                       ALL_BONDED_IN,
	output logic                            ALL_BONDED_OUT,
	output logic                            ALL_BONDED_OE_N,
	// receive channel side
	input  wire logic                       CHAR_STROBE,
	input  wire bond_pkg::rx_chan_type      RX_CHAN,
	output logic      [bond_pkg::NUM_CH-1:0] OFFSET_ADJUST_EN,
	output logic      [bond_pkg::NUM_CH-1:0] EB_INSERT,
	output logic      [bond_pkg::NUM_CH-1:0] EB_DELETE
);
	localparam int N = bond_pkg::NUM_CH;

	// synchronised pins
	logic [bond_pkg::PIN_W-1:0] pins_s;
	logic                       master_sel_s;
	logic                       inhibit_n_s;
	logic [1:0]                 master_ch;
	logic [1:0]                 lines_s;
	logic                       all_bonded_s;

	// register state
	bond_pkg::ctrl_type      ctrl;
	bond_pkg::res_state_type state;
	bond_pkg::res_state_type next_state;
	logic [1:0]              bond_status;
	logic [1:0]              next_bond_status;
	logic [1:0]              cmd_d1;
	logic [1:0]              cmd_d2;
	logic [N-1:0]            pend_ins;
	logic [N-1:0]            pend_del;

	// decode wires
	logic        wr_en;
	logic        rd_setup;
	logic        hit_ctrl;
	logic        hit_stat;
	logic        restart;
	logic        mode_active;
	logic        is_master;
	logic        is_slave;
	logic        master_in_group;
	logic [N-1:0] member;
	logic        all_seq;
	logic [N-1:0] free_set;
	logic [N-1:0] next_adjust;
	logic        release_all;
	logic [1:0]  cmd;
	logic [N-1:0] set_ins;
	logic [N-1:0] set_del;
	logic [N-1:0] apply_ins;
	logic [N-1:0] apply_del;
	bond_pkg::stat_type stat_word;
	bond_pkg::ctrl_type wr_word;
	bond_pkg::ctrl_type wr_ctrl;

	// encode the master channel's buffer event for one character
	function automatic logic [1:0] encode_event(input logic add,
		input logic drop);
		if (add)
			return bond_pkg::BS_INSERT;
		else if (drop)
			return bond_pkg::BS_DELETE;
		else
			return bond_pkg::BS_NORMAL;
	endfunction : encode_event

	// every pin comes from outside the clock domain
	pin_sync2 #(
		.W       (bond_pkg::PIN_W),
		.RST_VAL (bond_pkg::PIN_RESET)
	) u_pin_sync (
		.clk  (SYS_CLK),
		.rstn (RSTN),
		.d    ({MASTER_SEL, BOND_INHIBIT_N, MASTER_CHANNEL_SELECT_HI,
			MASTER_CHANNEL_SELECT_LO, BOND_STATUS_LINES_IN,
			ALL_BONDED_IN}),
		.q    (pins_s)
	);
	assign master_sel_s = pins_s[6];
	assign inhibit_n_s  = pins_s[5];
	assign master_ch    = pins_s[4:3];
	assign lines_s      = pins_s[2:1];
	assign all_bonded_s = pins_s[0];

	// apb decode; zero wait states, so pready is simply high
	assign wr_en    = PSEL & PENABLE & PWRITE;
	assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
	assign hit_ctrl = (PADDR == bond_pkg::ADDR_CTRL);
	assign hit_stat = (PADDR == bond_pkg::ADDR_STAT);
	assign PREADY   = 1'b1;
	assign PSLVERR  = PSEL & PENABLE & ~(hit_ctrl | hit_stat);
	assign wr_word  = bond_pkg::ctrl_type'(PWDATA);
	assign restart  = wr_en & hit_ctrl & wr_word.restart;

	// only group and clock mode are stored; restart and reserved read 0
	always_comb begin
		wr_ctrl             = bond_pkg::CTRL_RESET;
		wr_ctrl.group       = wr_word.group;
		wr_ctrl.ref_clocked = wr_word.ref_clocked;
	end

	// mode and role; straps mean nothing outside bonded ref-clocked mode
	assign mode_active = (ctrl.group == bond_pkg::GROUP_ALL) &
		ctrl.ref_clocked;
	assign is_master   = mode_active & ~master_sel_s;
	assign is_slave    = mode_active & master_sel_s;

	// group membership needs the master channel inside it
	assign master_in_group = ctrl.group[master_ch];
	assign member   = master_in_group ? ctrl.group : '0;
	assign all_seq  = (&(RX_CHAN.seq_detected | ~member)) & (|member);
	assign free_set = member & RX_CHAN.seq_detected;
	assign next_adjust = inhibit_n_s ? free_set :
		(all_seq ? member : '0);

	// all-bonded is released only after resolution with every frame valid
	assign release_all = (state == bond_pkg::RES_DONE) &
		(&RX_CHAN.framing_valid);

	// master status follows its channel at character rate
	assign next_bond_status = CHAR_STROBE ?
		encode_event(RX_CHAN.eb_add[master_ch],
			RX_CHAN.eb_drop[master_ch]) : bond_status;

	// master uses its own code delayed like a slave's synchroniser, so
	// both sides act on the same framing character
	assign cmd = is_master ? cmd_d2 :
		(is_slave ? lines_s : bond_pkg::BS_NORMAL);
	assign set_ins = (CHAR_STROBE & (cmd == bond_pkg::BS_INSERT)) ?
		member : '0;
	assign set_del = (CHAR_STROBE & (cmd == bond_pkg::BS_DELETE)) ?
		member : '0;
	assign apply_ins = pend_ins & RX_CHAN.framing_char & {N{CHAR_STROBE}};
	assign apply_del = pend_del & RX_CHAN.framing_char & {N{CHAR_STROBE}};

	// open drain pins only ever pull low
	assign BOND_STATUS_LINES_OUT = 2'b00;
	assign ALL_BONDED_OUT        = 1'b0;

	// status word
	always_comb begin
		stat_word              = '0;
		stat_word.master       = is_master;
		stat_word.active       = mode_active;
		stat_word.resolved     = (state == bond_pkg::RES_DONE);
		stat_word.all_bonded   = all_bonded_s;
		stat_word.lines        = lines_s;
		stat_word.seq_detected = RX_CHAN.seq_detected;
		stat_word.adjust_en    = OFFSET_ADJUST_EN;
	end

	// resolution sequencing; leaving the mode aborts it
	always_comb begin
		case (state)
			bond_pkg::RES_OFF:
				next_state = mode_active ? bond_pkg::RES_RESOLVE : state;
			bond_pkg::RES_RESOLVE:
				next_state = all_seq ? bond_pkg::RES_DONE : state;
			bond_pkg::RES_DONE:
				next_state = restart ? bond_pkg::RES_RESOLVE : state;
			default:
				next_state = bond_pkg::RES_OFF;
		endcase
		if (!mode_active)
			next_state = bond_pkg::RES_OFF;
	end

	// apb registers; read data captured in setup so it is a flop
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			ctrl   <= bond_pkg::CTRL_RESET;
			PRDATA <= '0;
		end else begin
			if (wr_en & hit_ctrl)
				ctrl <= wr_ctrl;
			if (rd_setup)
				PRDATA <= hit_ctrl ? ctrl : (hit_stat ? stat_word : '0);
		end
	end

	// state, status code and command pipe
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			state       <= bond_pkg::RES_OFF;
			bond_status <= bond_pkg::BS_NORMAL;
			cmd_d1      <= bond_pkg::BS_NORMAL;
			cmd_d2      <= bond_pkg::BS_NORMAL;
		end else begin
			state       <= next_state;
			bond_status <= next_bond_status;
			cmd_d1      <= bond_status;
			cmd_d2      <= cmd_d1;
		end
	end

	// pin enables: low means this device pulls the wire low
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			BOND_STATUS_LINES_OE_N <= 2'b11;
			ALL_BONDED_OE_N        <= 1'b1;
		end else begin
			BOND_STATUS_LINES_OE_N <= ~({2{is_master}} &
				~next_bond_status);
			ALL_BONDED_OE_N <= ~(mode_active & ~release_all);
		end
	end

	// pending commands per channel; a new command wins over the clear
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			pend_ins         <= '0;
			pend_del         <= '0;
			EB_INSERT        <= '0;
			EB_DELETE        <= '0;
			OFFSET_ADJUST_EN <= '0;
		end else begin
			pend_ins         <= (pend_ins & ~apply_ins) | set_ins;
			pend_del         <= (pend_del & ~apply_del) | set_del;
			EB_INSERT        <= apply_ins;
			EB_DELETE        <= apply_del;
			OFFSET_ADJUST_EN <= next_adjust;
		end
	end

	// checks
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);

	sequence s_ins_due;
		pend_ins[0] && CHAR_STROBE && RX_CHAN.framing_char[0];
	endsequence
	// pulse now, pending cleared unless a new command landed meanwhile
	sequence s_ins_pulse;
		EB_INSERT[0] && (pend_ins[0] == $past(set_ins[0]));
	endsequence

	a_slave_lines_free: assert property (
		!is_master |=> BOND_STATUS_LINES_OE_N == 2'b11)
		else $error("lines driven while not master");
	a_master_delete_code: assert property (
		is_master && CHAR_STROBE && !RX_CHAN.eb_add[master_ch] &&
		RX_CHAN.eb_drop[master_ch]
		|=> BOND_STATUS_LINES_OE_N == bond_pkg::BS_DELETE)
		else $error("delete code not driven");
	a_master_insert_code: assert property (
		is_master && CHAR_STROBE && RX_CHAN.eb_add[master_ch]
		|=> (BOND_STATUS_LINES_OE_N == bond_pkg::BS_INSERT) and
		(is_master && !CHAR_STROBE |=>
		BOND_STATUS_LINES_OE_N == bond_pkg::BS_INSERT))
		else $error("insert code not held for the character");
	a_strap_ignored: assert property (
		!mode_active |=> ALL_BONDED_OE_N && BOND_STATUS_LINES_OE_N == 2'b11)
		else $error("pins driven outside bonding mode");
	a_pull_low_resolving: assert property (
		mode_active && state == bond_pkg::RES_RESOLVE |=> !ALL_BONDED_OE_N)
		else $error("all-bonded released while resolving");
	a_release_when_done: assert property (
		mode_active && release_all |=> ALL_BONDED_OE_N)
		else $error("all-bonded held low after resolution");
	a_inhibit_holds: assert property (
		!inhibit_n_s && !all_seq |=> OFFSET_ADJUST_EN == '0)
		else $error("offset adjusted before all channels saw sequence");
	a_channel_free: assert property (
		inhibit_n_s |=> OFFSET_ADJUST_EN == $past(free_set))
		else $error("channel alignment not independent");
	a_master_outside: assert property (
		!master_in_group |=> OFFSET_ADJUST_EN == '0)
		else $error("group bonded without master channel");
	a_master_pipe: assert property (
		is_master ##2 is_master |-> cmd == $past(bond_status, 2))
		else $error("master command misaligned with slaves");
	a_insert_applied: assert property (
		s_ins_due |=> s_ins_pulse)
		else $error("pending insert not applied at framing char");
endmodule : multi_device_channel_bonding_ctrl
`default_nettype wire

/* verif/bond_partner.sv */
`timescale 1ns/10ps
`default_nettype none
// other device of the bonding domain, seen only through its open-drain pins
module bond_partner (
	// clock
	input  wire logic       clk,
	// bench controls
	input  wire logic       is_master,
	input  wire logic [1:0] code,
	input  wire logic       resolving,
	// open-drain enables, low pulls the wire low
	output logic      [1:0] lines_oe_n,
	output logic            bonded_oe_n
);
	// released lines float to the pull-up, so no stale code lingers
	always_ff @(posedge clk) begin
		lines_oe_n  <= is_master ? code : 2'h3;
		bonded_oe_n <= !resolving;
	end
endmodule : bond_partner
`default_nettype wire

/* verif/multi_device_channel_bonding_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module multi_device_channel_bonding_ctrl_tb;
	logic                  sys_clk;
	logic                  rstn;
	logic                  psel;
	logic                  penable;
	logic                  pwrite;
	logic [7:0]            paddr;
	logic [31:0]           pwdata;
	logic [31:0]           prdata;
	logic [31:0]           rd;
	logic                  pready;
	logic                  pslverr;
	logic                  master_sel;
	logic                  inhibit_n;
	logic                  sel_lo;
	logic                  sel_hi;
	logic [1:0]            lines_out;
	logic                  bonded_out;
	logic                  strobe;
	logic [1:0]            lines_oe_n;
	logic [1:0]            p_lines_oe_n;
	logic [1:0]            p_code;
	logic                  bonded_oe_n;
	logic                  p_bonded_oe_n;
	logic                  p_master;
	logic                  p_resolving;
	bond_pkg::rx_chan_type rx;
	logic [3:0]            adj;
	logic [3:0]            ins;
	logic [3:0]            del;
	logic [3:0]            ins_seen;
	logic [3:0]            del_seen;
	int                    num_errors;
	int                    check_count;
	// both wires have pull-ups: wired-AND of every device's enable
	// an enabled pin shows its output value, a released one the pull-up
	wire  [1:0]            lines_wire  = (lines_oe_n | lines_out) &
		p_lines_oe_n;
	wire                   bonded_wire = (bonded_oe_n | bonded_out) &
		p_bonded_oe_n;

	multi_device_channel_bonding_ctrl dut (
		.SYS_CLK(sys_clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .MASTER_SEL(master_sel),
		.BOND_INHIBIT_N(inhibit_n), .MASTER_CHANNEL_SELECT_LO(sel_lo),
		.MASTER_CHANNEL_SELECT_HI(sel_hi), .BOND_STATUS_LINES_IN(lines_wire),
		.BOND_STATUS_LINES_OUT(lines_out), .BOND_STATUS_LINES_OE_N(lines_oe_n),
		.ALL_BONDED_IN(bonded_wire), .ALL_BONDED_OUT(bonded_out),
		.ALL_BONDED_OE_N(bonded_oe_n), .CHAR_STROBE(strobe), .RX_CHAN(rx),
		.OFFSET_ADJUST_EN(adj), .EB_INSERT(ins), .EB_DELETE(del));

	bond_partner partner (.clk(sys_clk), .is_master(p_master), .code(p_code),
		.resolving(p_resolving), .lines_oe_n(p_lines_oe_n),
		.bonded_oe_n(p_bonded_oe_n));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// hang guard at 20000 cycles, far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		num_errors++;
		stop_test();
	end

	task automatic stop_test;
		if (num_errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test

	task automatic check(input string nm, input logic [31:0] e, got);
		check_count++;
		if (got !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, e, got);
		end
	endtask : check

	// one apb transfer; read data and error are taken at the pready edge
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic err);
		@(posedge sys_clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		check("pslverr", 32'(err), 32'(pslverr));
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e,
		input logic err);
		apb(1'b0, a, 32'h0, err);
		check("read data", e, rd & m);
	endtask : rd_chk

	// wait n falling edges; the first one still sees a one-cycle pulse
	task automatic cyc(input int n);
		repeat (n) begin
			@(negedge sys_clk);
			ins_seen |= ins;
			del_seen |= del;
		end
	endtask : cyc

	// one character: strobe for one cycle, then three quiet cycles
	task automatic char(input logic [3:0] add, drop, fc, input logic [1:0] c);
		@(posedge sys_clk);
		strobe          <= 1'b1;
		rx.eb_add       <= add;
		rx.eb_drop      <= drop;
		rx.framing_char <= fc;
		p_code          <= c;
		@(posedge sys_clk);
		strobe          <= 1'b0;
		rx.eb_add       <= 4'h0;
		rx.eb_drop      <= 4'h0;
		rx.framing_char <= 4'h0;
		cyc(3);
	endtask : char

	// command character, a plain one, then one with framing on all channels
	task automatic flow(input logic [3:0] add, drop, input logic [1:0] c, oe,
		input logic [3:0] ei, ed);
		ins_seen = 4'h0;
		del_seen = 4'h0;
		char(add, drop, 4'h0, c);
		check("status lines", 32'(oe), 32'(lines_oe_n));
		char(4'h0, 4'h0, 4'h0, bond_pkg::BS_NORMAL);
		char(4'h0, 4'h0, 4'hF, bond_pkg::BS_NORMAL);
		check("insert", 32'(ei), 32'(ins_seen));
		check("delete", 32'(ed), 32'(del_seen));
	endtask : flow

	initial begin
		rstn        = 1'b0;
		psel        = 1'b0;
		penable     = 1'b0;
		pwrite      = 1'b0;
		paddr       = 8'h00;
		pwdata      = 32'h0;
		master_sel  = 1'b0;
		inhibit_n   = 1'b0;
		sel_lo      = 1'b0;
		sel_hi      = 1'b0;
		strobe      = 1'b0;
		rx          = '0;
		p_master    = 1'b0;
		p_code      = 2'h3;
		p_resolving = 1'b0;
		num_errors  = 0;
		check_count = 0;
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		rd_chk(bond_pkg::ADDR_CTRL, 32'hFFFFFFFF, bond_pkg::CTRL_RESET, 1'b0);
		apb(1'b1, 8'h08, 32'h1F, 1'b1);
		rd_chk(8'h08, 32'hFFFFFFFF, 32'h0, 1'b1);
		rd_chk(bond_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h0, 1'b0);
		// group without the master channel: nothing bonds, pins released
		rx.seq_detected <= 4'hF;
		apb(1'b1, bond_pkg::ADDR_CTRL, 32'h1E, 1'b0);
		cyc(6);
		check("adjust", 32'h0, 32'(adj));
		check("status lines", 32'h3, 32'(lines_oe_n));
		check("all bonded", 32'h1, 32'(bonded_oe_n));
		// full bonding as master with inhibit asserted
		@(posedge sys_clk);
		rx.seq_detected  <= 4'h0;
		rx.framing_valid <= 4'h7;
		apb(1'b1, bond_pkg::ADDR_CTRL, 32'h1F, 1'b0);
		cyc(6);
		check("all bonded", 32'h0, 32'(bonded_oe_n));
		rd_chk(bond_pkg::ADDR_STAT, 32'h3, 32'h3, 1'b0);
		@(posedge sys_clk);
		rx.seq_detected <= 4'h7;
		cyc(6);
		check("adjust", 32'h0, 32'(adj));
		@(posedge sys_clk);
		rx.seq_detected <= 4'hF;
		cyc(6);
		check("adjust", 32'hF, 32'(adj));
		check("all bonded", 32'h0, 32'(bonded_oe_n));
		@(posedge sys_clk);
		rx.framing_valid <= 4'hF;
		p_resolving      <= 1'b1;
		cyc(6);
		check("all bonded", 32'h1, 32'(bonded_oe_n));
		rd_chk(bond_pkg::ADDR_STAT, 32'h8, 32'h0, 1'b0);
		@(posedge sys_clk);
		p_resolving <= 1'b0;
		cyc(4);
		rd_chk(bond_pkg::ADDR_STAT, 32'h8, 32'h8, 1'b0);
		flow(4'h1, 4'h0, 2'h3, bond_pkg::BS_INSERT, 4'hF, 4'h0);
		flow(4'h0, 4'h1, 2'h3, bond_pkg::BS_DELETE, 4'h0, 4'hF);
		flow(4'h2, 4'h0, 2'h3, bond_pkg::BS_NORMAL, 4'h0, 4'h0);
		@(posedge sys_clk);
		sel_lo <= 1'b1;
		cyc(4);
		flow(4'h2, 4'h0, 2'h3, bond_pkg::BS_INSERT, 4'hF, 4'h0);
		@(posedge sys_clk);
		sel_lo <= 1'b0;
		sel_hi <= 1'b1;
		cyc(4);
		flow(4'h0, 4'h4, 2'h3, bond_pkg::BS_DELETE, 4'h0, 4'hF);
		flow(4'h4, 4'h4, 2'h3, bond_pkg::BS_INSERT, 4'hF, 4'h0);
		// inhibit released after a restart: channels align one by one
		@(posedge sys_clk);
		inhibit_n       <= 1'b1;
		rx.seq_detected <= 4'h0;
		apb(1'b1, bond_pkg::ADDR_CTRL, 32'h11F, 1'b0);
		rd_chk(bond_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h1F, 1'b0);
		cyc(6);
		check("all bonded", 32'h0, 32'(bonded_oe_n));
		@(posedge sys_clk);
		rx.seq_detected <= 4'h2;
		cyc(6);
		check("adjust", 32'h2, 32'(adj));
		rd_chk(bond_pkg::ADDR_STAT, 32'hFFFFFFFF, 32'h2233, 1'b0);
		// slave: partner is master and drives the lines
		@(posedge sys_clk);
		rx.seq_detected <= 4'hF;
		master_sel      <= 1'b1;
		p_master        <= 1'b1;
		cyc(6);
		rd_chk(bond_pkg::ADDR_STAT, 32'h7, 32'h6, 1'b0);
		flow(4'h0, 4'h0, bond_pkg::BS_INSERT, 2'h3, 4'hF, 4'h0);
		flow(4'h0, 4'h0, bond_pkg::BS_DELETE, 2'h3, 4'h0, 4'hF);
		flow(4'h0, 4'h0, bond_pkg::BS_RESERVED, 2'h3, 4'h0, 4'h0);
		// interface not reference-clocked: strap ignored, pins released
		@(posedge sys_clk);
		master_sel <= 1'b0;
		p_master   <= 1'b0;
		apb(1'b1, bond_pkg::ADDR_CTRL, 32'h0F, 1'b0);
		cyc(6);
		check("status lines", 32'h3, 32'(lines_oe_n));
		check("all bonded", 32'h1, 32'(bonded_oe_n));
		stop_test();
	end
endmodule : multi_device_channel_bonding_ctrl_tb
`default_nettype wire
